//--- core/dcer_mem_array.sv
/*
  Storage array of the embedded memory block: one synchronous write port
  and one combinational read port.
  Assumes the caller registers addresses and data; contents are not reset.
*/
`timescale 1ns/100ps
module dcer_mem_array
  import dcer_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read of the word being written returns the old contents
  assign rd_data = mem[rd_addr];

endmodule

//--- core/dcer_pkg.sv
/*
  Package for the dual-clock embedded RAM: widths, reset values and the
  dual-port / single-port mode encoding.
  Assumes the user logic holds the mode steady while the memory is in use.
*/
package dcer_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int DEPTH  = 256;

  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // Gray-adjacent codes; 2'h2 is not a legal mode
  typedef enum logic [1:0] {
    DCER_MODE_RW = 2'h0,
    DCER_MODE_IO = 2'h1,
    DCER_MODE_SP = 2'h3
  } dcer_mode_e;

endpackage

//--- core/dcer_ram.sv
/*
  Embedded memory block with registered ports: read/write clock mode,
  input/output clock mode and single-port mode.
  Assumes one system clock; each side's slower clock arrives as a
  one-cycle enable. Clear inputs are sampled synchronously.
*/
// Functional notes
// - Two dual-port modes selectable by configuration
// - Input clock captures all input registers except the read side in read/write mode
// - Output registers follow only the output clock
// - Separate enables and clears per register side
// - Local, global or chip reset clears registers
// - Single-port mode shares one address

`timescale 1ns/100ps
module dcer_ram
  import dcer_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic [1:0]        mode,
  input  wire logic              in_ce,
  input  wire logic              out_ce,
  input  wire logic              in_clr,
  input  wire logic              out_clr,
  input  wire logic              global_clr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_strobe,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic              read_strobe,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_valid
);

  logic              in_grp_clr;
  logic              out_grp_clr;
  logic              rd_cap_ce;
  logic              rd_cap_clr;
  logic              mode_rw;
  logic              mode_sp;
  logic              mem_wr_en;
  logic [DATA_W-1:0] mem_q;

  logic [DATA_W-1:0] wd_ff;
  logic              we_ff;
  logic [ADDR_W-1:0] wa_ff;
  logic              rd_req_ff;
  logic [ADDR_W-1:0] ra_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic              rd_valid_ff;

  // Mode decode is shared by the datapath and the checks
  function automatic logic mode_is(
    input logic [1:0] m,
    input dcer_mode_e code
  );
    return (m == code);
  endfunction

  assign mode_rw = mode_is(mode, DCER_MODE_RW);
  assign mode_sp = mode_is(mode, DCER_MODE_SP);

  // Each side has its own clear; the global clear and reset reach both
  assign in_grp_clr  = in_clr  | global_clr | srst;
  assign out_grp_clr = out_clr | global_clr | srst;

  // Read/write clock mode moves the read-side inputs to the output clock
  assign rd_cap_ce  = mode_rw ? out_ce      : in_ce;
  assign rd_cap_clr = mode_rw ? out_grp_clr : in_grp_clr;

  // Write-side input registers
  always_ff @(posedge clock) begin
    if (in_grp_clr) begin
      wd_ff <= DATA_RST;
      we_ff <= 1'b0;
      wa_ff <= ADDR_RST;
    end else if (in_ce) begin
      wd_ff <= wr_data;
      we_ff <= wr_strobe;
      wa_ff <= wr_addr;
    end
  end

  // Read-side input registers
  always_ff @(posedge clock) begin
    if (rd_cap_clr) begin
      rd_req_ff <= 1'b0;
      ra_ff     <= ADDR_RST;
    end else if (rd_cap_ce) begin
      // Single port: one address, and a write blocks the read
      rd_req_ff <= read_strobe & ~(mode_sp & wr_strobe);
      ra_ff <= mode_sp ? wr_addr : rd_addr;
    end
  end

  // Store happens at the enabled input edge after the strobe was captured
  assign mem_wr_en = in_ce & we_ff & ~in_grp_clr;

  dcer_mem_array u_mem (
    .clock   (clock),
    .wr_en   (mem_wr_en),
    .wr_addr (wa_ff),
    .wr_data (wd_ff),
    .rd_addr (ra_ff),
    .rd_data (mem_q)
  );

  // Output registers; the data word holds until the next read or an output-side clear
  always_ff @(posedge clock) begin
    if (out_grp_clr) begin
      rd_data_ff  <= DATA_RST;
      rd_valid_ff <= 1'b0;
    end else if (out_ce) begin
      rd_valid_ff <= rd_req_ff;
      if (rd_req_ff) begin
        rd_data_ff <= mem_q;
      end
    end
  end

  assign rd_data  = rd_data_ff;
  assign rd_valid = rd_valid_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  wr_capture_a: assert property (
    in_ce && !in_grp_clr |=> we_ff == $past(wr_strobe) && wa_ff == $past(wr_addr))
    else $error("write inputs not captured on input enable");

  out_hold_a: assert property (
    !out_ce && !out_grp_clr |=> $stable(rd_data_ff) && $stable(rd_valid_ff))
    else $error("output register changed without output enable");

  in_clear_a: assert property (
    in_clr |=> !we_ff && wa_ff == ADDR_RST && wd_ff == DATA_RST)
    else $error("input clear did not clear input registers");

  out_indep_a: assert property (
    mode == DCER_MODE_IO && in_clr && !out_clr && !global_clr && !out_ce
    |=> $stable(rd_valid_ff) && $stable(rd_data_ff))
    else $error("input clear disturbed output registers");

  glob_clear_a: assert property (
    global_clr |=> !rd_valid_ff && !we_ff && !rd_req_ff && rd_data_ff == DATA_RST)
    else $error("global clear missed a register");

  glob_in_a: assert property (
    global_clr |=> wa_ff == ADDR_RST && ra_ff == ADDR_RST && wd_ff == DATA_RST)
    else $error("global clear missed an address or data register");

  local_clear_a: assert property (
    in_clr && !mode_rw |=> !rd_req_ff && ra_ff == ADDR_RST)
    else $error("local clear missed a read-side register");

  rw_mode_a: assert property (
    mode_rw && !in_ce && out_ce && !out_grp_clr |=> rd_req_ff == $past(read_strobe))
    else $error("read side not on output enable in read/write mode");

  rw_clear_a: assert property (
    mode_rw && out_clr |=> !rd_req_ff && ra_ff == ADDR_RST)
    else $error("output clear missed read side in read/write mode");

  sp_addr_a: assert property (
    mode_sp && in_ce && !in_grp_clr
    |=> ra_ff == $past(wr_addr) && (!$past(wr_strobe) || !rd_req_ff))
    else $error("single-port address or write priority wrong");

  sp_block_a: assert property (
    mode_sp && in_ce && !in_grp_clr && wr_strobe
    |=> !rd_req_ff)
    else $error("single-port write did not block the read");

  ra_capture_a: assert property (
    mode_is(mode, DCER_MODE_IO) && in_ce && !in_grp_clr
    |=> ra_ff == $past(rd_addr) && rd_req_ff == $past(read_strobe))
    else $error("read inputs not captured on input enable");

  in_hold_a: assert property (
    !in_ce && !in_grp_clr
    |=> $stable(we_ff) && $stable(wa_ff) && $stable(wd_ff))
    else $error("write inputs changed without input enable");

  io_side_a: assert property (
    !mode_rw && !in_ce && !in_grp_clr
    |=> $stable(rd_req_ff) && $stable(ra_ff))
    else $error("read inputs changed without input enable");

  wr_gate_a: assert property (
    !in_ce |-> !mem_wr_en)
    else $error("array written without input enable");

  out_clear_a: assert property (
    out_clr |=> !rd_valid_ff && rd_data_ff == DATA_RST)
    else $error("output clear did not clear output registers");

  rd_data_a: assert property (
    out_ce && rd_req_ff && !out_grp_clr |=> rd_valid_ff && rd_data_ff == $past(mem_q))
    else $error("read data not presented on output enable");

  valid_follow_a: assert property (
    out_ce && !out_grp_clr
    |=> rd_valid_ff == $past(rd_req_ff))
    else $error("valid flag does not follow the captured read");

  data_hold_a: assert property (
    out_ce && !out_grp_clr && !rd_req_ff
    |=> $stable(rd_data_ff))
    else $error("read data changed without a read");

  // A word stored at one edge is what a read of that address sees next
  wr_to_rd_a: assert property (
    mem_wr_en ##1 (out_ce && rd_req_ff && !out_grp_clr && ra_ff == $past(wa_ff))
    |=> rd_data_ff == $past(wd_ff, 2))
    else $error("written word not read back");

  io_read_c: cover property (mode_is(mode, DCER_MODE_IO) && out_ce && rd_req_ff);
  rw_read_c: cover property (mode_rw && mem_wr_en ##[1:4] rd_valid_ff);
  sp_write_c: cover property (mode_sp && mem_wr_en);
  clr_c: cover property (rd_valid_ff ##1 out_clr);
  slow_out_c: cover property (rd_req_ff && !out_ce ##1 out_ce);

endmodule

//--- testbench/dcer_fabric_ce.sv
/*
  Partner model: fabric logic making the output-side clock enable.
  Assumes the system clock; div 0 gives an enable every cycle.
*/
`timescale 1ns/100ps
module dcer_fabric_ce
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [2:0] div,
  output logic            ce
);
  logic [2:0] cnt_ff;
  always_ff @(posedge clock) begin
    if (srst || cnt_ff >= div)
      cnt_ff <= 3'h0;
    else
      cnt_ff <= cnt_ff + 3'h1;
  end
  // A sparse enable stands in for a slower output clock
  assign ce = (cnt_ff == div);
endmodule

//--- testbench/test_dual_clock_embedded_ram.sv
/*
  Testbench of the dual-clock RAM: traffic in modes 1, 0 and 3.
  Assumes dcer_pkg and the partner enable model compile first.
*/
`timescale 1ns/100ps
module test_dual_clock_embedded_ram;
  import dcer_pkg::*;
  logic              clock = 0, srst = 1, in_ce = 1, in_clr = 0, out_clr = 0;
  logic              global_clr = 0, wr_strobe = 0, read_strobe = 0, out_ce, rd_valid;
  logic [1:0]        mode = 2'h1;
  logic [2:0]        div = 3'h0;
  logic [ADDR_W-1:0] wr_addr = 8'h00, rd_addr = 8'h00;
  logic [DATA_W-1:0] wr_data = 16'h0000, rd_data;
  int                err_total = 0, checked = 0;
  dcer_fabric_ce u_ce (.clock(clock), .srst(srst), .div(div), .ce(out_ce));
  dcer_ram u_dut (.clock(clock), .srst(srst), .mode(mode), .in_ce(in_ce),
    .out_ce(out_ce), .in_clr(in_clr), .out_clr(out_clr), .global_clr(global_clr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .read_strobe(read_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid));
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    step();
    wr_strobe = 1;
    wr_addr = a;
    wr_data = d;
    step();
    wr_strobe = 0;
    step();
  endtask
  // Clearing first drops any stale valid flag left by a slow enable
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    out_clr = 1;
    step();
    out_clr = 0;
    read_strobe = 1;
    rd_addr = a;
    wr_addr = a;
    // Strobe stands until an output edge takes it; a slow enable would drop it
    for (n = 0; n < 20 && rd_valid !== 1'b1; n++) step();
    read_strobe = 0;
    chk({15'h0000, rd_valid}, 16'h0001);
    chk(rd_data, exp);
  endtask
  task automatic summarize();
    $display("Checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clock);
    #1;
    srst = 0;
    chk(rd_data, DATA_RST);
    chk({15'h0000, rd_valid}, 16'h0000);
    wr(8'h00, 16'hA5C3);
    wr(8'hFF, 16'h5A3C);
    rd(8'h00, 16'hA5C3);
    rd(8'hFF, 16'h5A3C);
    div = 3'h3;
    rd(8'h00, 16'hA5C3);
    div = 3'h0;
    in_ce = 0;
    wr(8'h00, 16'h1111);
    in_ce = 1;
    rd(8'h00, 16'hA5C3);
    global_clr = 1;
    step();
    global_clr = 0;
    chk(rd_data, DATA_RST);
    div = 3'h3;
    in_clr = 1;
    wr(8'h00, 16'h2222);
    in_clr = 0;
    rd(8'h00, 16'hA5C3);
    div = 3'h0;
    mode = 2'h0;
    wr(8'h10, 16'hBEEF);
    rd(8'h10, 16'hBEEF);
    in_ce = 0;
    rd(8'h10, 16'hBEEF);
    in_ce = 1;
    mode = 2'h3;
    wr(8'h20, 16'hC0DE);
    rd(8'h20, 16'hC0DE);
    summarize();
  end
endmodule
